// ==== etx_fifo.sv ====
module etx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
  } etx_fifo_t;
  etx_fifo_t s;
  etx_fifo_t next_s;
  logic push;
  logic pop;

  // pointer and count update
  always_comb
  begin
    next_s = s;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    if (push)
    begin
      next_s.mem[s.wr] = i_in_data;
      next_s.wr = s.wr + 1'b1;
    end
    if (pop)
      next_s.rd = s.rd + 1'b1;
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush)
    begin
      next_s.rd = '0;
      next_s.wr = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_in_ready = (s.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (s.cnt != '0);
  assign o_out_data = s.mem[s.rd];
endmodule

// ==== etx_host_model.sv ====
module etx_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clear,
  input  wire logic        i_data_ready,
  input  wire logic [10:0] i_limit,
  output logic             o_data_valid,
  output logic [7:0]       o_data,
  output logic [10:0]      o_sent
);
  timeunit 1ns;
  timeprecision 1ns;

  // bytes follow command and length
  // offer held until taken, stall at limit
  assign o_data_valid = i_reset_n && (o_sent < i_limit);
  // idle data shows inverse of last byte
  assign o_data = o_data_valid ? 8'(o_sent * 11'h007 + 11'h003)
                               : ~8'(o_sent * 11'h007 - 11'h004);

  // count of bytes taken by the block
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_sent <= 11'h000;
    else if (i_clear)
      o_sent <= 11'h000;
    else if (o_data_valid && i_data_ready)
      o_sent <= o_sent + 11'h001;
  end
endmodule

// ==== etx_pkg.sv ====
package etx_pkg;
  // register indices
  localparam logic [7:0] REG_TX_IRQ_EN   = 8'h07;
  localparam logic [7:0] REG_TX_CMD      = 8'h09;
  localparam logic [7:0] REG_BUF_IRQ_EN  = 8'h0b;
  localparam logic [7:0] REG_LINE_CTL    = 8'h13;
  localparam logic [7:0] REG_TEST_CTL    = 8'h19;
  localparam logic [7:0] REG_TX_LENGTH   = 8'h46;
  localparam logic [7:0] REG_TX_STATUS   = 8'h20;
  // line and test control fields
  localparam int LC_TX_EN      = 7;
  localparam int LC_FORCE_AUI  = 8;
  localparam int LC_AUTO_PORT  = 9;
  localparam int LC_MOD_BACKOFF = 11;
  localparam int LC_ONE_DEFER  = 13;
  localparam int TC_LINK_TEST_DIS = 7;
  // transmit command fields
  localparam int CMD_START_LO  = 6;
  localparam int CMD_FORCE     = 8;
  localparam int CMD_NO_CRC    = 12;
  localparam int CMD_NO_PAD    = 13;
  // transmit and buffer irq enable fields
  localparam int TI_CRS_LOSS   = 6;
  localparam int TI_SQE        = 7;
  localparam int TI_TX_OK      = 8;
  localparam int TI_LATE_COL   = 9;
  localparam int TI_JABBER     = 10;
  localparam int TI_ANY_COL    = 11;
  localparam int TI_16_COL     = 15;
  localparam int BI_SPACE      = 8;
  localparam int BI_UNDERRUN   = 9;
  localparam int BI_COL_OVF    = 12;
  // reset values
  localparam logic [15:0] RST_REG = 16'h0000;
  // start thresholds and frame sizes
  localparam logic [10:0] THR_5    = 11'd5;
  localparam logic [10:0] THR_381  = 11'd381;
  localparam logic [10:0] THR_1021 = 11'd1021;
  localparam logic [10:0] MIN_WITH_CRC = 11'd64;
  localparam logic [10:0] MIN_NO_CRC   = 11'd60;
  localparam logic [10:0] CRC_BYTES    = 11'd4;
  localparam logic [3:0]  PREAMBLE_BYTES = 4'd7;
  localparam logic [7:0]  PREAMBLE_BYTE  = 8'h55;
  localparam logic [7:0]  SFD_BYTE       = 8'hd5;
  localparam logic [31:0] CRC_INIT       = 32'hffffffff;
  localparam logic [31:0] CRC_POLY       = 32'hedb88320;
  // one byte on a 10 Mb/s line: 800 ns
  localparam int BYTE_TIME_NS  = 800;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BYTE_CYCLES   = BYTE_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== etx_tx_path.sv ====
// What this block does
// - command and length first, then serialisation
// - preamble starts at chosen byte threshold
// - host bytes sent in buffer order
// - pad short frames to minimum
// - append 32-bit crc unless inhibited
// - line transmit enable gates all sending
// - forced aui overrides; both force and auto clear picks twisted pair
// - auto port select unless forced aui
// - backoff bit picks modified backoff
// - deferral bit selects single-part deferral
// - no link pulses on twisted pair: send only if test-disabled
// - irq enable writes act immediately
// - enables: carrier loss, sqe, tx ok
// - enables: late collision, jabber, any collision
// - enable for sixteen attempts
// - enable for tx buffer space
// - enable for transmit underrun
// - enable for collision counter overflow
// - backoff and deferral bits change anytime
// - command bits 7:6 encode start threshold
// - pad to 64 with crc, 60 without
module etx_tx_path #(
  parameter int FIFO_DEPTH = 4,
  parameter int BUF_DEPTH  = 2048
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  input  wire logic        i_data_valid,
  output logic             o_data_ready,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_link_ok,
  input  wire logic        i_aui_carrier,
  input  wire logic        i_col,
  input  wire logic        i_sqe,
  input  wire logic        i_jabber,
  input  wire logic        i_late_col,
  input  wire logic        i_retry16,
  input  wire logic        i_col_ovf,
  output logic             o_tx_en,
  output logic [7:0]       o_tx_data,
  output logic             o_aui_sel,
  output logic             o_mod_backoff,
  output logic             o_one_part_defer,
  output logic [15:0]      o_event_irq
);
  typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_PRE, ST_DATA, ST_PAD, ST_CRC} etx_state_t;
  typedef struct packed {
    etx_state_t  st;
    logic [15:0] tx_irq_en;
    logic [15:0] buf_irq_en;
    logic [15:0] line_ctl;
    logic [15:0] test_ctl;
    logic [15:0] cmd;
    logic [10:0] len;
    logic [10:0] got;
    logic [10:0] sent;
    logic [3:0]  pcnt;
    logic [4:0]  tick;
    logic [31:0] crc;
    logic        tx_en;
    logic [7:0]  tx_data;
    logic        aui_sel;
    logic        underrun;
    logic [15:0] irq;
    logic [15:0] rdata;
    logic [2:0]  link_s;
    logic [2:0]  crs_s;
  } etx_regs_t;
  etx_regs_t s;
  etx_regs_t next_s;

  logic        f_valid;
  logic        f_ready;
  logic [7:0]  f_data;
  logic        f_pop;
  logic        f_flush;
  logic        b_valid;
  logic        b_ready;
  logic [7:0]  b_data;
  logic        in_ready;
  logic        in_take;
  logic [10:0] thr;
  logic [10:0] min_len;
  logic        byte_tick;
  logic        may_send;

  etx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_flush     (f_flush),
    .i_in_valid  (i_data_valid && in_take),
    .o_in_ready  (in_ready),
    .i_in_data   (i_data),
    .o_out_valid (b_valid),
    .i_out_ready (b_ready),
    .o_out_data  (b_data)
  );

  // frame buffer behind the input fifo, deep enough for every start threshold
  etx_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_frame_buf (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_flush     (f_flush),
    .i_in_valid  (b_valid),
    .o_in_ready  (b_ready),
    .i_in_data   (b_data),
    .o_out_valid (f_valid),
    .i_out_ready (f_pop),
    .o_out_data  (f_data)
  );

  // crc over one byte, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ etx_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction

  always_comb
  begin
    next_s = s;
    f_pop = 1'b0;
    f_flush = 1'b0;
    // pin sync: three flops before use
    next_s.link_s = {s.link_s[1:0], i_link_ok};
    next_s.crs_s = {s.crs_s[1:0], i_aui_carrier};
    case (s.cmd[etx_pkg::CMD_START_LO +: 2])
      2'b00: thr = etx_pkg::THR_5;
      2'b01: thr = etx_pkg::THR_381;
      2'b10: thr = etx_pkg::THR_1021;
      default: thr = s.len;
    endcase
    if (thr > s.len)
      thr = s.len;
    min_len = s.cmd[etx_pkg::CMD_NO_CRC] ? etx_pkg::MIN_WITH_CRC
                                         : etx_pkg::MIN_WITH_CRC - etx_pkg::CRC_BYTES;
    if (!s.cmd[etx_pkg::CMD_NO_CRC] && !s.cmd[etx_pkg::CMD_NO_PAD])
      min_len = etx_pkg::MIN_WITH_CRC - etx_pkg::CRC_BYTES;
    else if (s.cmd[etx_pkg::CMD_NO_CRC] && !s.cmd[etx_pkg::CMD_NO_PAD])
      min_len = etx_pkg::MIN_NO_CRC;
    else
      min_len = 11'd0;
    // twisted pair needs link or test bypass
    may_send = s.line_ctl[etx_pkg::LC_TX_EN]
               && (s.aui_sel || s.link_s[2] || s.test_ctl[etx_pkg::TC_LINK_TEST_DIS]);
    byte_tick = (s.tick == 5'(etx_pkg::BYTE_CYCLES - 1));
    next_s.tick = byte_tick ? 5'd0 : s.tick + 5'd1;
    in_take = (s.st != ST_IDLE) && (s.got < s.len);
    if (i_data_valid && in_take && in_ready)
      next_s.got = s.got + 11'd1;
    // forced aui wins; auto picks by link
    if (s.line_ctl[etx_pkg::LC_FORCE_AUI])
      next_s.aui_sel = 1'b1;
    else if (s.line_ctl[etx_pkg::LC_AUTO_PORT])
      next_s.aui_sel = !s.link_s[2];
    else
      next_s.aui_sel = 1'b0;
    // register writes; enables act at once
    if (i_reg_wr)
    begin
      if (i_reg_addr == etx_pkg::REG_TX_IRQ_EN)
        next_s.tx_irq_en = i_reg_wdata;
      else if (i_reg_addr == etx_pkg::REG_BUF_IRQ_EN)
        next_s.buf_irq_en = i_reg_wdata;
      else if (i_reg_addr == etx_pkg::REG_LINE_CTL)
        next_s.line_ctl = i_reg_wdata;
      else if (i_reg_addr == etx_pkg::REG_TEST_CTL)
        next_s.test_ctl = i_reg_wdata;
      else if (i_reg_addr == etx_pkg::REG_TX_CMD)
        next_s.cmd = i_reg_wdata;
      // length write opens the buffer phase
      else if (i_reg_addr == etx_pkg::REG_TX_LENGTH && s.st == ST_IDLE && i_reg_wdata != '0)
      begin
        next_s.len = i_reg_wdata[10:0];
        next_s.got = 11'd0;
        next_s.sent = 11'd0;
        next_s.st = ST_FILL;
      end
    end
    // tx engine, one byte per byte time; the last byte stands until the next tick
    next_s.tx_en = byte_tick ? 1'b0 : s.tx_en;
    case (s.st)
      ST_IDLE:
        next_s.underrun = 1'b0;
      ST_FILL:
        if (s.cmd[etx_pkg::CMD_FORCE])
        begin
          f_flush = 1'b1;
          next_s.st = ST_IDLE;
          next_s.cmd[etx_pkg::CMD_FORCE] = 1'b0;
        end
        else if (s.got >= thr && may_send && byte_tick)
        begin
          next_s.st = ST_PRE;
          next_s.pcnt = 4'd0;
          next_s.crc = etx_pkg::CRC_INIT;
        end
      ST_PRE:
        if (byte_tick)
        begin
          next_s.tx_en = 1'b1;
          next_s.tx_data = (s.pcnt == etx_pkg::PREAMBLE_BYTES) ? etx_pkg::SFD_BYTE
                                                               : etx_pkg::PREAMBLE_BYTE;
          next_s.pcnt = s.pcnt + 4'd1;
          if (s.pcnt == etx_pkg::PREAMBLE_BYTES)
            next_s.st = ST_DATA;
        end
        else
          next_s.tx_en = s.tx_en;
      ST_DATA:
        if (byte_tick)
        begin
          next_s.tx_en = 1'b1;
          if (!f_valid)
          begin
            next_s.underrun = 1'b1;
            next_s.tx_en = 1'b0;
            f_flush = 1'b1;
            next_s.st = ST_IDLE;
          end
          else
          begin
            f_pop = 1'b1;
            next_s.tx_data = f_data;
            next_s.crc = crc_byte(s.crc, f_data);
            next_s.sent = s.sent + 11'd1;
            if (s.sent + 11'd1 == s.len)
              next_s.st = (s.sent + 11'd1 < min_len) ? ST_PAD
                        : (s.cmd[etx_pkg::CMD_NO_CRC] ? ST_IDLE : ST_CRC);
          end
        end
        else
          next_s.tx_en = s.tx_en;
      ST_PAD:
        if (byte_tick)
        begin
          next_s.tx_en = 1'b1;
          next_s.tx_data = 8'h00;
          next_s.crc = crc_byte(s.crc, 8'h00);
          next_s.sent = s.sent + 11'd1;
          if (s.sent + 11'd1 >= min_len)
            next_s.st = s.cmd[etx_pkg::CMD_NO_CRC] ? ST_IDLE : ST_CRC;
        end
        else
          next_s.tx_en = s.tx_en;
      ST_CRC:
        if (byte_tick)
        begin
          next_s.tx_en = 1'b1;
          next_s.tx_data = ~s.crc[7:0];
          next_s.crc = {8'hff, s.crc[31:8]};
          next_s.pcnt = s.pcnt + 4'd1;
          if (s.pcnt == etx_pkg::PREAMBLE_BYTES + 4'd4)
            next_s.st = ST_IDLE;
        end
        else
          next_s.tx_en = s.tx_en;
      default:
        next_s.st = ST_IDLE;
    endcase
    if (!s.line_ctl[etx_pkg::LC_TX_EN])
      next_s.tx_en = 1'b0;
    next_s.irq = 16'h0000;
    next_s.irq[etx_pkg::TI_CRS_LOSS] = s.tx_irq_en[etx_pkg::TI_CRS_LOSS] && s.aui_sel
                                       && s.st == ST_DATA && s.sent == 11'd0 && byte_tick
                                       && !s.crs_s[2];
    next_s.irq[etx_pkg::TI_SQE] = s.tx_irq_en[etx_pkg::TI_SQE] && i_sqe;
    next_s.irq[etx_pkg::TI_TX_OK] = s.tx_irq_en[etx_pkg::TI_TX_OK] && s.st != ST_IDLE
                                    && next_s.st == ST_IDLE && !next_s.underrun && !f_flush;
    next_s.irq[etx_pkg::TI_LATE_COL] = s.tx_irq_en[etx_pkg::TI_LATE_COL] && i_late_col;
    next_s.irq[etx_pkg::TI_JABBER] = s.tx_irq_en[etx_pkg::TI_JABBER] && i_jabber;
    next_s.irq[etx_pkg::TI_ANY_COL] = s.tx_irq_en[etx_pkg::TI_ANY_COL] && i_col;
    next_s.irq[etx_pkg::TI_16_COL] = s.tx_irq_en[etx_pkg::TI_16_COL] && i_retry16;
    next_s.irq[etx_pkg::BI_SPACE - 8] = s.buf_irq_en[etx_pkg::BI_SPACE]
                                        && s.st == ST_IDLE && next_s.st == ST_FILL;
    next_s.irq[etx_pkg::BI_UNDERRUN - 8] = s.buf_irq_en[etx_pkg::BI_UNDERRUN]
                                           && next_s.underrun && !s.underrun;
    next_s.irq[etx_pkg::BI_COL_OVF - 8] = s.buf_irq_en[etx_pkg::BI_COL_OVF] && i_col_ovf;
    // read mux
    next_s.rdata = 16'h0000;
    if (i_reg_rd)
    begin
      if (i_reg_addr == etx_pkg::REG_TX_IRQ_EN)
        next_s.rdata = s.tx_irq_en;
      else if (i_reg_addr == etx_pkg::REG_BUF_IRQ_EN)
        next_s.rdata = s.buf_irq_en;
      else if (i_reg_addr == etx_pkg::REG_LINE_CTL)
        next_s.rdata = s.line_ctl;
      else if (i_reg_addr == etx_pkg::REG_TEST_CTL)
        next_s.rdata = s.test_ctl;
      else if (i_reg_addr == etx_pkg::REG_TX_CMD)
        next_s.rdata = s.cmd;
      else if (i_reg_addr == etx_pkg::REG_TX_STATUS)
        next_s.rdata = {s.underrun, 9'h000, s.aui_sel, s.link_s[2], 1'b0, 3'(s.st)};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s <= '0;
      s.st <= ST_IDLE;
    end
    else
      s <= next_s;
  end

  assign o_data_ready = in_ready && in_take;
  assign o_reg_rdata = s.rdata;
  assign o_tx_en = s.tx_en;
  assign o_tx_data = s.tx_data;
  assign o_aui_sel = s.aui_sel;
  assign o_mod_backoff = s.line_ctl[etx_pkg::LC_MOD_BACKOFF];
  assign o_one_part_defer = s.line_ctl[etx_pkg::LC_ONE_DEFER];
  assign o_event_irq = s.irq;

  tx_gate_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !s.line_ctl[etx_pkg::LC_TX_EN] |=> !o_tx_en) else $error("tx while disabled");
  aui_forced_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s.line_ctl[etx_pkg::LC_FORCE_AUI] |=> o_aui_sel) else $error("aui not forced");
  auto_port_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s.line_ctl[9:8] == 2'b10 && !s.link_s[2] |=> o_aui_sel) else $error("auto select");
  // backoff bit follows a write at once
  backoff_bit_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_reg_wr && i_reg_addr == etx_pkg::REG_LINE_CTL
    |=> o_mod_backoff == $past(i_reg_wdata[etx_pkg::LC_MOD_BACKOFF]))
    else $error("backoff bit");
  // deferral bit follows a write at once
  defer_bit_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_reg_wr && i_reg_addr == etx_pkg::REG_LINE_CTL
    |=> o_one_part_defer == $past(i_reg_wdata[etx_pkg::LC_ONE_DEFER]))
    else $error("defer");
  start_thr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s.st == ST_FILL ##1 s.st == ST_PRE |-> $past(s.got) >= $past(thr)) else $error("early");
  link_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s.st == ST_FILL && !s.aui_sel && !s.link_s[2] && !s.test_ctl[etx_pkg::TC_LINK_TEST_DIS]
    |=> s.st != ST_PRE) else $error("no link send");
  crc_after_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s.st == ST_CRC |-> !s.cmd[etx_pkg::CMD_NO_CRC]) else $error("crc inhibited");
  pad_short_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s.st == ST_PAD |-> s.sent < min_len) else $error("pad too long");
  txok_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_event_irq[etx_pkg::TI_TX_OK] |-> $past(s.tx_irq_en[etx_pkg::TI_TX_OK]))
    else $error("txok gate");
  cov_frame: cover property (@(posedge i_clk) s.st == ST_DATA ##[1:1000] s.st == ST_CRC);
  cov_pad: cover property (@(posedge i_clk) s.st == ST_PAD);
  cov_under: cover property (@(posedge i_clk) $rose(s.underrun));
  cov_aui_frame: cover property (@(posedge i_clk) s.aui_sel && s.st == ST_DATA);
  cov_thr_wait: cover property (@(posedge i_clk) s.st == ST_FILL && s.got == etx_pkg::THR_381);
endmodule

// ==== etx_tx_path_tb_top.sv ====
module etx_tx_path_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk       = 1'b0;
  logic        i_reset_n   = 1'b0;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [7:0]  i_reg_addr  = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_link_ok   = 1'b1;
  logic [5:0]  ev          = 6'h00;
  logic        clear       = 1'b0;
  logic [10:0] limit       = 11'h000;
  logic        tx_seen     = 1'b0;
  logic        ok_seen     = 1'b0;
  logic [15:0] irq_seen    = 16'h0000;
  logic [3:0]  phase       = 4'h0;
  logic [15:0] o_reg_rdata;
  logic [15:0] o_event_irq;
  logic [7:0]  i_data;
  logic [7:0]  o_tx_data;
  logic [10:0] sent;
  logic        i_data_valid;
  logic        o_data_ready;
  logic        o_tx_en;
  logic        o_aui_sel;
  logic        o_mod_backoff;
  logic        o_one_part_defer;
  logic [7:0]  cap[$];
  int          fails   = 0;
  int          n_tests = 0;

  always #25 i_clk = ~i_clk;

  etx_tx_path dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_data_valid(i_data_valid), .o_data_ready(o_data_ready),
    .i_data(i_data), .i_link_ok(i_link_ok), .i_aui_carrier(1'b0), .i_col(ev[0]),
    .i_sqe(ev[1]), .i_jabber(ev[2]), .i_late_col(ev[3]), .i_retry16(ev[4]),
    .i_col_ovf(ev[5]), .o_tx_en(o_tx_en), .o_tx_data(o_tx_data), .o_aui_sel(o_aui_sel),
    .o_mod_backoff(o_mod_backoff), .o_one_part_defer(o_one_part_defer),
    .o_event_irq(o_event_irq));

  etx_host_model host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clear(clear),
    .i_data_ready(o_data_ready), .i_limit(limit), .o_data_valid(i_data_valid),
    .o_data(i_data), .o_sent(sent));

  // line byte capture at mid-byte
  always @(posedge i_clk)
  begin
    phase <= o_tx_en ? phase + 4'h1 : 4'h0;
    if (o_tx_en && phase == 4'h8)
      cap.push_back(o_tx_data);
    if (o_tx_en)
      tx_seen <= 1'b1;
    if (o_event_irq[etx_pkg::TI_TX_OK])
      ok_seen <= 1'b1;
    if (o_event_irq != 16'h0000)
      irq_seen <= irq_seen | o_event_irq;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  task automatic wait_tx(input logic v, input int n);
    for (int k = 0; k < n && o_tx_en !== v; k++)
      @(posedge i_clk);
    #1;
  endtask

  task automatic start(input logic [15:0] cmd, input logic [10:0] len, input logic [10:0] lim);
    @(posedge i_clk);
    clear <= 1'b1;
    limit <= 11'h000;
    irq_seen <= 16'h0000;
    wr(etx_pkg::REG_TX_CMD, cmd);
    wr(etx_pkg::REG_TX_LENGTH, {5'h00, len});
    clear   <= 1'b0;
    limit   <= lim;
    tx_seen <= 1'b0;
    ok_seen <= 1'b0;
    cap.delete();
  endtask

  task automatic t_regs();
    logic [7:0]  a[3] = '{etx_pkg::REG_TX_IRQ_EN, etx_pkg::REG_BUF_IRQ_EN, etx_pkg::REG_LINE_CTL};
    logic [15:0] m[3] = '{16'h8fc0, 16'h1300, 16'h2b00};
    logic [15:0] d;
    for (int i = 0; i < 3; i++)
    begin
      rd(a[i], d);
      chk(d, etx_pkg::RST_REG);
      wr(a[i], m[i]);
      rd(a[i], d);
      chk(d, m[i]);
      wr(a[i], 16'h0000);
    end
    rd(8'h3f, d);
    chk(d, 16'h0000);
    $display("test regs done");
  endtask

  // port bits changed with transmit off
  task automatic t_line();
    wr(etx_pkg::REG_LINE_CTL, 16'h2900);
    repeat (3) @(posedge i_clk);
    chk({o_aui_sel, o_mod_backoff, o_one_part_defer}, 16'h0007);
    i_link_ok <= 1'b0;
    wr(etx_pkg::REG_LINE_CTL, 16'h0200);
    repeat (3) @(posedge i_clk);
    chk({o_aui_sel, o_mod_backoff, o_one_part_defer}, 16'h0004);
    i_link_ok <= 1'b1;
    wr(etx_pkg::REG_LINE_CTL, 16'h0000);
    repeat (3) @(posedge i_clk);
    chk({o_aui_sel, o_mod_backoff, o_one_part_defer}, 16'h0000);
    $display("test line done");
  endtask

  task automatic t_irq();
    int   enb[6] = '{11, 7, 10, 9, 15, 12};
    int   outb[6] = '{11, 7, 10, 9, 15, 4};
    logic seen;
    for (int i = 0; i < 6; i++)
      for (int e = 0; e < 2; e++)
      begin
        wr(i == 5 ? etx_pkg::REG_BUF_IRQ_EN : etx_pkg::REG_TX_IRQ_EN, 16'(e) << enb[i]);
        @(posedge i_clk);
        ev[i] <= 1'b1;
        @(posedge i_clk);
        ev[i] <= 1'b0;
        seen = 1'b0;
        repeat (4) @(posedge i_clk) seen |= o_event_irq[outb[i]];
        chk(seen, 16'(e));
      end
    $display("test irq done");
  endtask

  task automatic t_frame(input logic [15:0] mode, input logic [10:0] len);
    logic [7:0]  exp[$];
    logic [31:0] crc;
    logic [7:0]  b;
    int          minlen;
    minlen = mode[etx_pkg::CMD_NO_PAD] ? 0 : 60;
    crc = etx_pkg::CRC_INIT;
    start(mode, len, len);
    wait_tx(1'b1, 400);
    wait_tx(1'b0, 3000);
    repeat (7) exp.push_back(etx_pkg::PREAMBLE_BYTE);
    exp.push_back(etx_pkg::SFD_BYTE);
    for (int i = 0; i < len || i < minlen; i++)
    begin
      b = i < len ? 8'(i * 8'h07 + 8'h03) : 8'h00;
      exp.push_back(b);
      for (int j = 0; j < 8; j++)
        crc = (crc[0] ^ b[j]) ? (crc >> 1) ^ etx_pkg::CRC_POLY : crc >> 1;
    end
    for (int j = 0; j < 4 && !mode[etx_pkg::CMD_NO_CRC]; j++)
      exp.push_back(~crc[8*j +: 8]);
    chk(16'(cap.size()), 16'(exp.size()));
    foreach (exp[i])
      chk(cap[i], exp[i]);
    chk(ok_seen, 16'h0001);
    $display("test frame %h done", mode);
  endtask

  task automatic t_thr(input logic [15:0] cmd, input logic [10:0] len, input logic [10:0] hold);
    start(cmd, len, hold - 11'h001);
    for (int k = 0; k < 3000 && sent !== hold - 11'h001; k++)
      @(posedge i_clk);
    repeat (100) @(posedge i_clk);
    chk(tx_seen, 16'h0000);
    limit <= hold;
    wait_tx(1'b1, 150);
    chk(o_tx_en, 16'h0001);
    @(posedge i_clk);
    limit <= len;
    wait_tx(1'b0, 20000);
    $display("test threshold %h done", cmd);
  endtask

  // starved frame on the forced aui port, buffer events enabled
  task automatic t_under();
    wr(etx_pkg::REG_LINE_CTL, 16'h0000);
    wr(etx_pkg::REG_LINE_CTL, 16'h0180);
    wr(etx_pkg::REG_TX_IRQ_EN, 16'h0140);
    wr(etx_pkg::REG_BUF_IRQ_EN, 16'h0300);
    start(16'h0000, 11'h00a, 11'h005);
    wait_tx(1'b1, 400);
    wait_tx(1'b0, 3000);
    chk(16'(cap.size()), 16'h000d);
    chk(16'(irq_seen[etx_pkg::BI_UNDERRUN - 8]), 16'h0001);
    chk(16'(irq_seen[etx_pkg::BI_SPACE - 8]), 16'h0001);
    chk(16'(irq_seen[etx_pkg::TI_CRS_LOSS]), 16'h0001);
    chk(16'(ok_seen), 16'h0000);
    $display("test underrun done");
  endtask

  task automatic t_gate();
    wr(etx_pkg::REG_LINE_CTL, 16'h0000);
    i_link_ok <= 1'b0;
    start(16'h0000, 11'h00a, 11'h00a);
    repeat (300) @(posedge i_clk);
    chk(tx_seen, 16'h0000);
    wr(etx_pkg::REG_LINE_CTL, 16'h0080);
    repeat (300) @(posedge i_clk);
    chk(tx_seen, 16'h0000);
    wr(etx_pkg::REG_TEST_CTL, 16'h0080);
    wait_tx(1'b1, 300);
    chk(o_tx_en, 16'h0001);
    wait_tx(1'b0, 3000);
    $display("test gate done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_line();
    t_irq();
    wr(etx_pkg::REG_TX_IRQ_EN, 16'h0100);
    wr(etx_pkg::REG_LINE_CTL, 16'h0080);
    for (int m = 0; m < 4; m++)
      t_frame(16'(m) << 12, 11'h00a);
    t_thr(16'h0000, 11'h00a, 11'h005);
    t_thr(16'h0040, 11'h190, 11'h17d);
    t_thr(16'h0080, 11'h406, 11'h3fd);
    t_thr(16'h00c0, 11'h00c, 11'h00c);
    t_under();
    t_gate();
    final_report();
  end

  // watchdog against a hang
  initial
  begin
    repeat (90000) @(posedge i_clk);
    fails++;
    final_report();
  end
endmodule
